// ---- hdl/vpsr_pkg.sv ----
// Constants shared by the voice-detect page/status register bank.
// Assumes byte-wide register offsets and an 8-bit page selector.
package vpsr_pkg;
  // ----------------------------------------------------------------
  // Register offsets and pages
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SELECT_OFS = 8'h00;
  localparam logic [7:0] STATUS_ONE_OFS = 8'h77;
  localparam logic [7:0] CHECKSUM_OFS = 8'h7E;
  localparam logic [7:0] CFG_ONE_OFS = 8'h1E;
  localparam logic [7:0] CFG_TWO_OFS = 8'h1F;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_ONE = 8'h01;
  localparam logic [7:0] COEF_PAGE_FIRST = 8'h02;
  localparam logic [7:0] COEF_PAGE_LAST = 8'h04;
  localparam logic [7:0] PAGE_LAST_OFS = 8'h7F;
  localparam logic [7:0] PAGE_WRAP_OFS = 8'h08;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
  localparam logic [7:0] CFG_ONE_RST = 8'h20;
  localparam logic [7:0] CFG_TWO_RST = 8'h08;
  localparam logic [7:0] CHECKSUM_RST = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POLICY_LSB = 6;
  localparam int CHANNEL_LSB = 4;
  localparam int CLOCK_SEL_LSB = 2;
  localparam int RATE_LSB = 0;
  localparam int SOUT_IRQ_BIT = 6;
  localparam int DET_REC_BIT = 3;
  localparam int STATE_LSB = 5;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STATE_SLEEP = 3'h4;
  localparam logic [2:0] STATE_ALL_OFF = 3'h6;
  localparam logic [2:0] STATE_ACTIVE = 3'h7;
  localparam logic [1:0] POLICY_USER = 2'h0;
  localparam logic [1:0] POLICY_IRQ_BOTH = 2'h1;
  localparam logic [1:0] POLICY_IRQ_UP = 2'h2;
  localparam logic [1:0] POLICY_IRQ_DOWN = 2'h3;
  // External detector clock rates in kHz
  localparam logic [15:0] RATE0_KHZ = 16'h0C00;
  localparam logic [15:0] RATE1_KHZ = 16'h1800;
  localparam logic [15:0] RATE2_KHZ = 16'h3000;
  localparam logic [15:0] RATE3_KHZ = 16'h4800;
endpackage

// ---- hdl/vpsr_bus_if.sv ----
// Byte-level link between the two-wire bus engine and the register bank.
// Assumes both ends run on the same clock; strobes are one-cycle pulses.
`timescale 1ns/10ps
interface vpsr_bus_if;
  logic addrLoad; // First written byte is the register offset
  logic wrEn; // Data byte written at the current offset
  logic rdReq; // Fetch byte at the current offset
  logic [7:0] byteData; // Byte from the host
  logic [7:0] rdData; // Byte to the host, valid one cycle after rdReq
  modport engine (output addrLoad, output wrEn, output rdReq, output byteData, input rdData);
  modport bank (input addrLoad, input wrEn, input rdReq, input byteData, output rdData);
endinterface

// ---- hdl/vpsr_i2c_slave.sv ----
// Two-wire bus slave engine: start/stop, address match, ack, byte moves.
// Assumes SCL high and low phases each last several clk cycles.
`timescale 1ns/10ps
module vpsr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h4E // Arbitrary bus address
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  vpsr_bus_if.engine bus
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_MACK} vpsr_state_t;
  vpsr_state_t state;
  logic [2:0] sclSync; // Two-stage sync plus one delay for edges
  logic [2:0] sdaSync;
  logic [2:0] bitCnt; // Bits moved in this byte
  logic [7:0] shiftReg; // Byte being shifted
  logic isRead; // Direction of the current transfer
  logic isFirst; // Next written byte is the offset
  logic sclRise, sclFall, startSeen, stopSeen;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 0 feeds stage 1 only; edges use stages 1 and 2
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
    end else begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
    end
  end
  assign sclRise = sclSync[1] & ~sclSync[2];
  assign sclFall = ~sclSync[1] & sclSync[2];
  // Data edge while clock high marks start or stop
  assign startSeen = sclSync[1] & sclSync[2] & ~sdaSync[1] & sdaSync[2];
  assign stopSeen = sclSync[1] & sclSync[2] & sdaSync[1] & ~sdaSync[2];
  assign sdaOut = 1'b0; // Open drain: only ever pulls low

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      isRead <= 1'b0;
      isFirst <= 1'b0;
      sdaOeN <= 1'b1;
      bus.addrLoad <= 1'b0;
      bus.wrEn <= 1'b0;
      bus.rdReq <= 1'b0;
      bus.byteData <= 8'h00;
    end else begin
      bus.addrLoad <= 1'b0;
      bus.wrEn <= 1'b0;
      bus.rdReq <= 1'b0;
      if (startSeen) begin
        // Start or repeated start: address phase follows
        state <= ST_ADDR;
        bitCnt <= 3'h0;
        isFirst <= 1'b1;
        sdaOeN <= 1'b1;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOeN <= 1'b1;
      end else if (sclRise) begin
        case (state)
          ST_ADDR, ST_WRITE: begin
            shiftReg <= {shiftReg[6:0], sdaSync[1]};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= ST_ACK;
              if (state == ST_ADDR) begin
                isRead <= sdaSync[1];
                bus.rdReq <= sdaSync[1] & (shiftReg[6:0] == DEV_ADDR);
                if (shiftReg[6:0] != DEV_ADDR) begin
                  state <= ST_IDLE; // Not ours: stay silent
                end
              end else begin
                bus.byteData <= {shiftReg[6:0], sdaSync[1]};
                bus.addrLoad <= isFirst;
                bus.wrEn <= ~isFirst;
                isFirst <= 1'b0;
              end
            end
          end
          ST_MACK: begin
            // Host ack asks for another byte, nack ends the read
            if (sdaSync[1]) begin
              state <= ST_IDLE;
            end else begin
              bus.rdReq <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (sclFall) begin
        case (state)
          ST_ACK: begin
            if (sdaOeN) begin
              sdaOeN <= 1'b0; // Pull low for the ack bit
            end else if (isRead) begin
              state <= ST_READ;
              shiftReg <= bus.rdData;
              sdaOeN <= bus.rdData[7];
              bitCnt <= 3'h0;
            end else begin
              state <= ST_WRITE;
              sdaOeN <= 1'b1;
              bitCnt <= 3'h0;
            end
          end
          ST_READ: begin
            if (bitCnt == 3'h7) begin
              state <= ST_MACK;
              sdaOeN <= 1'b1; // Free the line for the host ack
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOeN <= shiftReg[6];
              bitCnt <= bitCnt + 3'h1;
            end
          end
          ST_MACK: begin
            state <= ST_READ;
            shiftReg <= bus.rdData;
            sdaOeN <= bus.rdData[7];
            bitCnt <= 3'h0;
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// ---- hdl/vpsr_page_status_registers.sv ----
// Page selector, transaction checksum, mode status and voice-detect config.
// Assumes host pins on sclIn/sdaIn; status inputs come from same-clock logic.
`timescale 1ns/10ps
module vpsr_page_status_registers #(
  parameter logic [6:0] DEV_ADDR = 7'h4E, // Arbitrary bus address
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic sleepMode,
  input wire logic [CHANNELS-1:0] channelOn,
  input wire logic recordingActive,
  input wire logic voiceDetectEnable,
  input wire logic detectorIrq,
  output logic [7:0] pageSelect,
  output logic [2:0] operatingStateField,
  output logic [1:0] autoPowerPolicy,
  output logic autoPowerUpByIrq,
  output logic autoPowerDownByIrq,
  output logic [1:0] monitoredChannelSelect,
  output logic [3:0] monitoredChannelMask,
  output logic [1:0] detectorClockSelect,
  output logic [1:0] detectorExternalClockRate,
  output logic [15:0] detectorClockKhz,
  output logic serialOutInterruptEnable,
  output logic detectDuringRecordingEnable,
  output logic detectorRun,
  output logic serialDataOutIrqSel,
  output logic serialDataOutIrq
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  vpsr_bus_if busLink();
  logic [7:0] cfgOne; // Voice-detect configuration one
  logic [7:0] transactionSumValue; // Running checksum
  logic [7:0] regPtr; // Current register offset
  logic [7:0] next_regPtr;
  logic pageWrap; // Offset on a coefficient page wraps into the next page
  logic ptrStep; // A byte was moved at regPtr

  // Offset decode on a given page
  function automatic logic regHit(input logic [7:0] pg, input logic [7:0] ofs,
                                  input logic [7:0] wantPg, input logic [7:0] wantOfs);
    regHit = (pg == wantPg) && (ofs == wantOfs);
  endfunction

  // Operating state code from power inputs
  function automatic logic [2:0] modeCode(input logic sleeping, input logic anyOn);
    if (sleeping) begin
      modeCode = vpsr_pkg::STATE_SLEEP;
    end else if (anyOn) begin
      modeCode = vpsr_pkg::STATE_ACTIVE;
    end else begin
      modeCode = vpsr_pkg::STATE_ALL_OFF;
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  vpsr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOeN(sdaOeN),
    .bus(busLink.engine)
  );

  // ----------------------------------------------------------------
  // Offset pointer
  // ----------------------------------------------------------------
  assign ptrStep = busLink.wrEn | busLink.rdReq;
  always_comb begin
    next_regPtr = regPtr + 8'h01;
    pageWrap = 1'b0;
    if (regPtr == vpsr_pkg::PAGE_LAST_OFS && pageSelect >= vpsr_pkg::COEF_PAGE_FIRST &&
        pageSelect <= vpsr_pkg::COEF_PAGE_LAST) begin
      next_regPtr = vpsr_pkg::PAGE_WRAP_OFS;
      pageWrap = 1'b1;
    end
  end

  // Offset byte loads; each moved byte advances
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regPtr <= 8'h00;
    end else if (busLink.addrLoad) begin
      regPtr <= busLink.byteData;
    end else if (ptrStep) begin
      regPtr <= next_regPtr;
    end
  end

  // ----------------------------------------------------------------
  // Page selector
  // ----------------------------------------------------------------
  // Present on every page; the wrap also advances it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pageSelect <= vpsr_pkg::PAGE_SELECT_RST;
    end else if (busLink.wrEn && regPtr == vpsr_pkg::PAGE_SELECT_OFS) begin
      pageSelect <= busLink.byteData;
    end else if (ptrStep && pageWrap) begin
      pageSelect <= pageSelect + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Voice-detect configuration
  // ----------------------------------------------------------------
  // Only page one holds these; same offsets elsewhere are left alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgOne <= vpsr_pkg::CFG_ONE_RST;
    end else if (busLink.wrEn && regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ONE, vpsr_pkg::CFG_ONE_OFS)) begin
      cfgOne <= busLink.byteData;
    end
  end

  // Only the two live bits of config two are stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serialOutInterruptEnable <= vpsr_pkg::CFG_TWO_RST[vpsr_pkg::SOUT_IRQ_BIT];
      detectDuringRecordingEnable <= vpsr_pkg::CFG_TWO_RST[vpsr_pkg::DET_REC_BIT];
    end else if (busLink.wrEn && regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ONE, vpsr_pkg::CFG_TWO_OFS)) begin
      serialOutInterruptEnable <= busLink.byteData[vpsr_pkg::SOUT_IRQ_BIT];
      detectDuringRecordingEnable <= busLink.byteData[vpsr_pkg::DET_REC_BIT];
    end
  end

  assign autoPowerPolicy = cfgOne[vpsr_pkg::POLICY_LSB +: 2];
  assign monitoredChannelSelect = cfgOne[vpsr_pkg::CHANNEL_LSB +: 2];
  assign detectorClockSelect = cfgOne[vpsr_pkg::CLOCK_SEL_LSB +: 2];
  assign detectorExternalClockRate = cfgOne[vpsr_pkg::RATE_LSB +: 2];

  // ----------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------
  // Adds each written data byte on every page, including unmapped offsets; a write to it on page zero loads the byte instead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transactionSumValue <= vpsr_pkg::CHECKSUM_RST;
    end else if (busLink.wrEn) begin
      if (regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ZERO, vpsr_pkg::CHECKSUM_OFS)) begin
        transactionSumValue <= busLink.byteData;
      end else begin
        transactionSumValue <= transactionSumValue + busLink.byteData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and derived controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operatingStateField <= vpsr_pkg::STATE_SLEEP;
    end else begin
      operatingStateField <= modeCode(sleepMode, |channelOn);
    end
  end

  // Decoded policy, channel mask and clock rate, registered for clean outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autoPowerUpByIrq <= 1'b0;
      autoPowerDownByIrq <= 1'b0;
      monitoredChannelMask <= 4'h0;
      detectorClockKhz <= 16'h0000;
    end else begin
      autoPowerUpByIrq <= autoPowerPolicy == vpsr_pkg::POLICY_IRQ_BOTH || autoPowerPolicy == vpsr_pkg::POLICY_IRQ_UP;
      autoPowerDownByIrq <= autoPowerPolicy == vpsr_pkg::POLICY_IRQ_BOTH ||
                            autoPowerPolicy == vpsr_pkg::POLICY_IRQ_DOWN;
      monitoredChannelMask <= 4'h1 << monitoredChannelSelect;
      case (detectorExternalClockRate)
        2'h0: detectorClockKhz <= vpsr_pkg::RATE0_KHZ;
        2'h1: detectorClockKhz <= vpsr_pkg::RATE1_KHZ;
        2'h2: detectorClockKhz <= vpsr_pkg::RATE2_KHZ;
        default: detectorClockKhz <= vpsr_pkg::RATE3_KHZ;
      endcase
    end
  end

  // Detector gating and serial-out interrupt routing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detectorRun <= 1'b0;
      serialDataOutIrqSel <= 1'b0;
      serialDataOutIrq <= 1'b0;
    end else begin
      detectorRun <= voiceDetectEnable && (!recordingActive || detectDuringRecordingEnable);
      serialDataOutIrqSel <= serialOutInterruptEnable && !recordingActive;
      serialDataOutIrq <= serialOutInterruptEnable && !recordingActive && detectorIrq;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Unmapped offsets read zero so a stray read is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busLink.rdData <= 8'h00;
    end else if (busLink.rdReq) begin
      if (regPtr == vpsr_pkg::PAGE_SELECT_OFS) begin
        busLink.rdData <= pageSelect;
      end else if (regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ZERO, vpsr_pkg::CHECKSUM_OFS)) begin
        busLink.rdData <= transactionSumValue;
      end else if (regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ZERO, vpsr_pkg::STATUS_ONE_OFS)) begin
        busLink.rdData <= {operatingStateField, 5'h00};
      end else if (regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ONE, vpsr_pkg::CFG_ONE_OFS)) begin
        busLink.rdData <= cfgOne;
      end else if (regHit(pageSelect, regPtr, vpsr_pkg::PAGE_ONE, vpsr_pkg::CFG_TWO_OFS)) begin
        busLink.rdData <= {1'b0, serialOutInterruptEnable, 2'b00, detectDuringRecordingEnable, 3'b000};
      end else begin
        busLink.rdData <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  status_code_a: assert property (
    sleepMode ##1 sleepMode |-> operatingStateField == 3'h4)
    else $error("status not sleep");
  checksum_read_a: assert property (
    busLink.rdReq && pageSelect == 8'h00 && regPtr == 8'h7E |=> busLink.rdData == $past(transactionSumValue))
    else $error("checksum readback wrong");
  checksum_load_a: assert property (
    busLink.wrEn && pageSelect == 8'h00 && regPtr == 8'h7E |=> transactionSumValue == $past(busLink.byteData))
    else $error("checksum not loaded");
  checksum_sum_a: assert property (
    busLink.wrEn && !(pageSelect == 8'h00 && regPtr == 8'h7E)
      |=> transactionSumValue == 8'($past(transactionSumValue) + $past(busLink.byteData)))
    else $error("checksum not accumulated");
  page_write_a: assert property (
    busLink.wrEn && regPtr == 8'h00 |=> pageSelect == $past(busLink.byteData))
    else $error("page not written");
  policy_decode_a: assert property (
    autoPowerPolicy == 2'h2 ##1 autoPowerPolicy == 2'h2 |-> autoPowerUpByIrq && !autoPowerDownByIrq)
    else $error("policy decode wrong");
  channel_mask_a: assert property (
    $stable(monitoredChannelSelect) |=> monitoredChannelMask == (4'h1 << $past(monitoredChannelSelect)))
    else $error("channel mask wrong");
  serial_data_out_pin_route_a: assert property (
    !serialOutInterruptEnable ##1 !serialOutInterruptEnable |-> !serialDataOutIrqSel && !serialDataOutIrq)
    else $error("serial out irq leaked");
  record_gate_a: assert property (
    recordingActive && !detectDuringRecordingEnable |=> !detectorRun)
    else $error("detector ran while recording");
  reserved_zero_a: assert property (
    busLink.rdReq && pageSelect == 8'h01 && regPtr == 8'h1F |=> (busLink.rdData & 8'hB7) == 8'h00)
    else $error("reserved bits not zero");
  cfg_reset_a: assert property (
    $rose(rst_n) |-> cfgOne == 8'h20 && detectDuringRecordingEnable && !serialOutInterruptEnable)
    else $error("config reset wrong");
  power_gate_a: assert property (
    !voiceDetectEnable |=> !detectorRun)
    else $error("detector ran while disabled");
  page_wrap_a: assert property (
    busLink.wrEn && regPtr == 8'h7F && pageSelect inside {8'h02, 8'h03, 8'h04}
      |=> regPtr == 8'h08 && pageSelect == 8'($past(pageSelect) + 8'h01))
    else $error("coefficient page wrap wrong");

  checksum_write_c: cover property (busLink.wrEn && pageSelect == 8'h00 && regPtr == 8'h7E);
  page_wrap_c: cover property (ptrStep && pageWrap);
  cfg_read_c: cover property (busLink.rdReq && pageSelect == 8'h01 && regPtr == 8'h1E);
  serial_data_out_pin_irq_c: cover property (serialDataOutIrq);
endmodule

// ---- test/vpsr_host_model.sv ----
// Two-wire bus host that configures the register bank.
// Assumes one shared clk; the SDA wire has a pull-up.
`timescale 1ns/10ps
module vpsr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h4E // Arbitrary bus address
) (
  input wire logic clk,
  input wire logic sdaOeN,
  output logic scl,
  output logic sda
);
  logic hostLow = 1'b0; // Host pulls SDA low
  initial scl = 1'b1;
  // Open drain: either party pulls low, else the pull-up wins
  assign sda = !hostLow && sdaOeN;
  // Phases of 10 clk leave margin over the 6 clk minimum
  task automatic half();
    repeat (10) @(posedge clk);
  endtask
  // SDA moves mid low phase, sampled late in the high phase
  task automatic bitX(input logic b, output logic s);
    half();
    hostLow <= !b;
    half();
    scl <= 1'b1;
    half();
    s = sda;
    scl <= 1'b0;
  endtask
  // Also serves as repeated start from a low SCL
  task automatic start();
    half();
    hostLow <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    hostLow <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    half();
    hostLow <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    hostLow <= 1'b0;
    half();
  endtask
  // Ack bit is left to the device
  task automatic sendByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(b[i], s);
    bitX(1'b1, s);
  endtask
  task automatic recvByte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
    bitX(!more, s);
  endtask
  // listed offsets only, reserved bits as zero
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input int n);
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(ofs);
    repeat (n) sendByte(d);
    stop();
  endtask
  // Single byte read ended by a host nack
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    start();
    sendByte({DEV_ADDR, 1'b0});
    sendByte(ofs);
    start();
    sendByte({DEV_ADDR, 1'b1});
    recvByte(1'b0, d);
    stop();
  endtask
endmodule

// ---- test/vpsr_page_status_registers_bench.sv ----
// Self-checking bench for the page/status register bank.
// Assumes the host model owns the bus pins.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module vpsr_page_status_registers_bench;
  typedef struct packed {logic [7:0] cfg; logic [1:0] upDn; logic [3:0] mask; logic [15:0] khz;} vpsr_row_t;
  logic clk = 1'b0, rst_n = 1'b0, sleepMode = 1'b0, recordingActive = 1'b0;
  logic voiceDetectEnable = 1'b0, detectorIrq = 1'b0, scl, sda, sdaOeN;
  logic [3:0] channelOn = 4'h0, monitoredChannelMask;
  logic [7:0] pageSelect, got, sum = 8'h00, pg = 8'h00;
  logic [2:0] operatingStateField;
  logic [1:0] autoPowerPolicy, monitoredChannelSelect, detectorClockSelect, detectorExternalClockRate;
  logic autoPowerUpByIrq, autoPowerDownByIrq, serialOutInterruptEnable, detectDuringRecordingEnable;
  logic detectorRun, serialDataOutIrqSel, serialDataOutIrq;
  logic [15:0] detectorClockKhz;
  // Config one fields and their decodes gathered for short compares
  logic [7:0] cfgSeen;
  logic [21:0] decSeen;
  assign cfgSeen = {autoPowerPolicy, monitoredChannelSelect, detectorClockSelect, detectorExternalClockRate};
  assign decSeen = {autoPowerUpByIrq, autoPowerDownByIrq, monitoredChannelMask, detectorClockKhz};
  int n_fail = 0, samples_checked = 0;
  // Config one code, {up, down} by irq, channel mask, clock in kHz
  vpsr_row_t rows [4] = '{'{8'h00, 2'b00, 4'h1, 16'h0C00}, '{8'h55, 2'b11, 4'h2, 16'h1800},
    '{8'hAA, 2'b10, 4'h4, 16'h3000}, '{8'hFF, 2'b01, 4'h8, 16'h4800}};
  vpsr_host_model host (.clk(clk), .sdaOeN(sdaOeN), .scl(scl), .sda(sda));
  vpsr_page_status_registers dut (.sclIn(scl), .sdaIn(sda), .sdaOut(), .*);
  initial forever #5 clk = ~clk;
  task automatic finish_test();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Write and keep the expected running checksum in step
  task automatic w(input logic [7:0] ofs, input logic [7:0] d, input int n);
    host.wr(ofs, d, n);
    sum = (ofs == vpsr_pkg::CHECKSUM_OFS && pg == vpsr_pkg::PAGE_ZERO) ? d : 8'(sum + d * n);
    if (ofs == vpsr_pkg::PAGE_SELECT_OFS) pg = d;
  endtask
  // Outputs lag their inputs by one or two clocks
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // Hang guard, about three times the expected run
  initial begin
    repeat (70000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    `CHK("page", 8'h00, pageSelect)
    `CHK("cfgOne", 8'h20, cfgSeen)
    `CHK("cfgTwo", 2'b01, {serialOutInterruptEnable, detectDuringRecordingEnable})
    rst_n <= 1'b1;
    settle();
    `CHK("state", 3'h6, operatingStateField)
    sleepMode <= 1'b1;
    settle();
    `CHK("state", 3'h4, operatingStateField)
    sleepMode <= 1'b0;
    channelOn <= 4'h4;
    settle();
    host.rd(vpsr_pkg::STATUS_ONE_OFS, got);
    `CHK("status", 8'hE0, got)
    w(8'h00, 8'h01, 1);
    `CHK("page", 8'h01, pageSelect)
    // Every code of every config one field
    foreach (rows[i]) begin
      w(vpsr_pkg::CFG_ONE_OFS, rows[i].cfg, 1);
      `CHK("fields", rows[i].cfg, cfgSeen)
      `CHK("decode", {rows[i].upDn, rows[i].mask, rows[i].khz}, decSeen)
      host.rd(vpsr_pkg::CFG_ONE_OFS, got);
      `CHK("readback", rows[i].cfg, got)
    end
    w(vpsr_pkg::CFG_TWO_OFS, 8'h40, 1);
    host.rd(vpsr_pkg::CFG_TWO_OFS, got);
    `CHK("cfgTwo", 8'h40, got)
    voiceDetectEnable <= 1'b1;
    recordingActive <= 1'b1;
    detectorIrq <= 1'b1;
    settle();
    `CHK("recording", 3'b000, {detectorRun, serialDataOutIrqSel, serialDataOutIrq})
    recordingActive <= 1'b0;
    settle();
    `CHK("idle", 3'b111, {detectorRun, serialDataOutIrqSel, serialDataOutIrq})
    voiceDetectEnable <= 1'b0;
    settle();
    `CHK("vadOff", 1'b0, detectorRun)
    w(vpsr_pkg::CFG_TWO_OFS, 8'h08, 1);
    voiceDetectEnable <= 1'b1;
    recordingActive <= 1'b1;
    settle();
    `CHK("recRun", 3'b100, {detectorRun, serialDataOutIrqSel, serialDataOutIrq})
    // Two bytes across the end of a coefficient page
    w(8'h00, 8'h02, 1);
    w(vpsr_pkg::PAGE_LAST_OFS, 8'h11, 2);
    pg = 8'h03;
    `CHK("wrapPage", 8'h03, pageSelect)
    w(8'h00, 8'h00, 1);
    host.rd(vpsr_pkg::CHECKSUM_OFS, got);
    `CHK("sum", sum, got)
    // Preload near the top so the sum wraps past 255
    w(vpsr_pkg::CHECKSUM_OFS, 8'hF0, 1);
    w(8'h00, 8'h01, 1);
    w(vpsr_pkg::CFG_ONE_OFS, 8'h25, 1);
    w(8'h00, 8'h00, 1);
    host.rd(vpsr_pkg::CHECKSUM_OFS, got);
    `CHK("sumWrap", sum, got)
    host.rd(8'h50, got);
    `CHK("unmapped", 8'h00, got)
    // Mid-run reset must bring back every value after reset
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("rstPage", 8'h00, pageSelect)
    `CHK("rstCfg", 8'h20, cfgSeen)
    `CHK("rstCfgTwo", 2'b01, {serialOutInterruptEnable, detectDuringRecordingEnable})
    `CHK("rstState", 3'h4, operatingStateField)
    rst_n <= 1'b1;
    // Synchronisers refill before the next start
    settle();
    host.rd(vpsr_pkg::CHECKSUM_OFS, got);
    `CHK("rstSum", 8'h00, got)
    finish_test();
  end
endmodule
